// ==== hw/eivm_defs.svh ====
// Offsets, field positions, reset values and vector addresses of the interrupt map.
`ifndef EIVM_DEFS_SVH
`define EIVM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------------
`define EIVM_ADDR_W 4
`define EIVM_OFS_CORE_CTRL 4'h0
`define EIVM_OFS_IRQ_ENABLE 4'h1
`define EIVM_OFS_IRQ_FLAGS 4'h2
`define EIVM_OFS_MASK_A 4'h3
`define EIVM_OFS_MASK_B 4'h4
`define EIVM_OFS_MASK_C 4'h5
`define EIVM_OFS_PIN_LEVEL 4'h6

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define EIVM_SENSE_A_LSB 0
`define EIVM_SENSE_B_LSB 2
`define EIVM_RST_BYTE 8'h00
`define EIVM_SETTLE_DONE 2'h3

// ----------------------------------------------------------------------------
// Program word vector addresses
// ----------------------------------------------------------------------------
`define EIVM_VEC_W 16
`define EIVM_VEC_N 21
`define EIVM_VEC_RESET 16'h0000
`define EIVM_VEC_EXT_A 16'h0001
`define EIVM_VEC_EXT_B 16'h0002
`define EIVM_VEC_PERIPH_FIRST 16'h0003
`define EIVM_VEC_PERIPH_LAST 16'h0012
`define EIVM_VEC_GRP_A 16'h000B
`define EIVM_VEC_GRP_B 16'h0013
`define EIVM_VEC_GRP_C 16'h0014
`define EIVM_PERIPH_N 15

`endif

// ==== hw/eivm_pkg.sv ====
// Types shared by the external interrupt and vector map block.
package eivm_pkg;

  typedef enum logic [1:0] {
    EIVM_SENSE_LOW = 2'h0,
    EIVM_SENSE_ANY = 2'h1,
    EIVM_SENSE_FALL = 2'h2,
    EIVM_SENSE_RISE = 2'h3
  } eivm_sense_e;

  // Common layout of the enable and flag registers.
  typedef struct packed {
    logic ext_b;
    logic ext_a;
    logic grp_a;
    logic grp_c;
    logic grp_b;
    logic [1:0] rsv;
    logic gie;
  } eivm_irq_bits_s;

endpackage

// ==== hw/eivm_top.sv ====
// External pin interrupts, pin-change groups and the vector map.
//
// Behaviour
// - Any reset starts fetching at word zero.
// - External pins vector to words one and two.
// - Change groups vector to 0x0B, 0x13, 0x14.
// - Peripheral vectors fill words 0x03 through 0x12, except 0x0B.
// - Vector fetched only for an enabled source.
// - Pin level triggers even when driven locally.
// - Group a requests on masked pins 7..0.
// - Group b requests on masked pins 10..8.
// - Group c requests on masked pins 17..11.
// - Per-pin masks gate each group request.
// - Pin change detection needs no I/O clock.
// - External sense: falling, rising, any change or low level.
// - Low level requests for as long as low.
// - Edge detection only while I/O clock runs.
// - Sense codes: low, any, falling, rising.
// - Edge flag set, cleared by vector or write.
// - Groups need own enable and global enable.
`timescale 1ns/10ps
`default_nettype none
`include "eivm_defs.svh"

module eivm_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

module eivm_top
  import eivm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // I/O clock running indication
  input wire logic io_clk_en_i,
  // Pins
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  input wire logic [17:0] change_watch_pins_i,
  // Peripheral requests, already gated by their own enables
  input wire logic [`EIVM_PERIPH_N-1:0] periph_req_i,
  // Processor core
  input wire logic core_ack_i,
  output logic irq_o,
  output logic [`EIVM_VEC_W-1:0] vector_o,
  output logic [`EIVM_VEC_N-1:0] ack_taken_o,
  // Register port
  input wire logic [`EIVM_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // The pad level is sampled whatever the pin direction, so software
  // driving its own pin raises its own interrupt.
  logic [19:0] pin_s;
  logic [19:0] pin_prev_r;
  logic [1:0] settle_r;
  logic armed;

  eivm_sync #(.W(20)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i({ext_irq_pin_b_i, ext_irq_pin_a_i, change_watch_pins_i}),
    .q_o(pin_s)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_prev_r <= '0;
    end else begin
      pin_prev_r <= pin_s;
    end
  end

  // Detection waits until the synchronisers hold real pin levels, which
  // keeps a high pin at reset release from looking like a change.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      settle_r <= 2'h0;
    end else if (settle_r != `EIVM_SETTLE_DONE) begin
      settle_r <= settle_r + 2'h1;
    end
  end
  assign armed = (settle_r == `EIVM_SETTLE_DONE);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [3:0] sense_r;
  eivm_irq_bits_s en_r;
  eivm_irq_bits_s flag_r;
  logic [7:0] mask_a_r;
  logic [2:0] mask_b_r;
  logic [6:0] mask_c_r;
  logic wr_flags;
  eivm_irq_bits_s wr_bits;

  assign wr_flags = reg_we_i && (reg_addr_i == `EIVM_OFS_IRQ_FLAGS);
  assign wr_bits = eivm_irq_bits_s'(reg_wdata_i);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sense_r <= 4'h0;
      en_r <= eivm_irq_bits_s'(`EIVM_RST_BYTE);
      mask_a_r <= 8'h00;
      mask_b_r <= 3'h0;
      mask_c_r <= 7'h00;
    end else if (reg_we_i) begin
      unique case (reg_addr_i)
        `EIVM_OFS_CORE_CTRL: sense_r <= reg_wdata_i[3:0];
        `EIVM_OFS_IRQ_ENABLE: begin
          en_r <= wr_bits;
          en_r.rsv <= 2'h0;
        end
        `EIVM_OFS_MASK_A: mask_a_r <= reg_wdata_i;
        `EIVM_OFS_MASK_B: mask_b_r <= reg_wdata_i[2:0];
        `EIVM_OFS_MASK_C: mask_c_r <= reg_wdata_i[6:0];
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // External pin sense
  // --------------------------------------------------------------------------
  eivm_sense_e sense_a;
  eivm_sense_e sense_b;
  logic edge_a;
  logic edge_b;

  assign sense_a = eivm_sense_e'(sense_r[`EIVM_SENSE_A_LSB +: 2]);
  assign sense_b = eivm_sense_e'(sense_r[`EIVM_SENSE_B_LSB +: 2]);

  function automatic logic sense_hit(input eivm_sense_e sel, input logic cur,
                                     input logic prev);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      EIVM_SENSE_LOW: hit = 1'b0;
      EIVM_SENSE_ANY: hit = cur ^ prev;
      EIVM_SENSE_FALL: hit = prev & ~cur;
      EIVM_SENSE_RISE: hit = cur & ~prev;
    endcase
    return hit;
  endfunction

  // Edges need the I/O clock; a level request does not.
  assign edge_a = armed && io_clk_en_i &&
                  sense_hit(sense_a, pin_s[18], pin_prev_r[18]);
  assign edge_b = armed && io_clk_en_i &&
                  sense_hit(sense_b, pin_s[19], pin_prev_r[19]);

  // --------------------------------------------------------------------------
  // Pin change groups
  // --------------------------------------------------------------------------
  logic [17:0] toggled;
  logic chg_a;
  logic chg_b;
  logic chg_c;

  // Change detection runs on any sampling clock, independent of the
  // I/O clock, so it can serve as a wake source.
  assign toggled = pin_s[17:0] ^ pin_prev_r[17:0];
  assign chg_a = armed && |(toggled[7:0] & mask_a_r);
  assign chg_b = armed && |(toggled[10:8] & mask_b_r);
  assign chg_c = armed && |(toggled[17:11] & mask_c_r);

  // --------------------------------------------------------------------------
  // Flags, set wins over clear
  // --------------------------------------------------------------------------
  logic [`EIVM_VEC_N-1:0] taken;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      flag_r <= eivm_irq_bits_s'(`EIVM_RST_BYTE);
    end else begin
      if (sense_a == EIVM_SENSE_LOW) begin
        flag_r.ext_a <= 1'b0;
      end else begin
        flag_r.ext_a <= edge_a | (flag_r.ext_a & ~(wr_flags & wr_bits.ext_a)
                                  & ~taken[1]);
      end
      if (sense_b == EIVM_SENSE_LOW) begin
        flag_r.ext_b <= 1'b0;
      end else begin
        flag_r.ext_b <= edge_b | (flag_r.ext_b & ~(wr_flags & wr_bits.ext_b)
                                  & ~taken[2]);
      end
      flag_r.grp_a <= chg_a | (flag_r.grp_a & ~(wr_flags & wr_bits.grp_a) & ~taken[11]);
      flag_r.grp_b <= chg_b | (flag_r.grp_b & ~(wr_flags & wr_bits.grp_b) & ~taken[19]);
      flag_r.grp_c <= chg_c | (flag_r.grp_c & ~(wr_flags & wr_bits.grp_c) & ~taken[20]);
    end
  end

  // --------------------------------------------------------------------------
  // Request vector, index equals program word address
  // --------------------------------------------------------------------------
  logic [`EIVM_VEC_N-1:0] req;
  logic lvl_a;
  logic lvl_b;

  assign lvl_a = (sense_a == EIVM_SENSE_LOW) && !pin_s[18];
  assign lvl_b = (sense_b == EIVM_SENSE_LOW) && !pin_s[19];

  always_comb begin
    req = '0;
    if (en_r.gie) begin
      req[1] = en_r.ext_a & (lvl_a | flag_r.ext_a);
      req[2] = en_r.ext_b & (lvl_b | flag_r.ext_b);
      req[10:3] = periph_req_i[7:0];
      req[11] = en_r.grp_a & flag_r.grp_a;
      req[18:12] = periph_req_i[14:8];
      req[19] = en_r.grp_b & flag_r.grp_b;
      req[20] = en_r.grp_c & flag_r.grp_c;
    end
  end

  // Lowest address wins; index zero is reset and never requested.
  function automatic logic [`EIVM_VEC_W-1:0] pick(input logic [`EIVM_VEC_N-1:0] r);
    logic [`EIVM_VEC_W-1:0] v;
    v = `EIVM_VEC_RESET;
    for (int i = `EIVM_VEC_N - 1; i >= 1; i--) begin
      if (r[i]) begin
        v = `EIVM_VEC_W'(i);
      end
    end
    return v;
  endfunction

  // --------------------------------------------------------------------------
  // Core side
  // --------------------------------------------------------------------------
  // Vector and request are registered together, so the core never sees a
  // request beside a stale address.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      vector_o <= `EIVM_VEC_RESET;
      irq_o <= 1'b0;
    end else begin
      irq_o <= |req;
      if (|req) begin
        vector_o <= pick(req);
      end
    end
  end

  always_comb begin
    taken = '0;
    if (core_ack_i && irq_o) begin
      taken[vector_o[4:0]] = 1'b1;
    end
  end
  assign ack_taken_o = taken;

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        `EIVM_OFS_CORE_CTRL: reg_rdata_o <= {4'h0, sense_r};
        `EIVM_OFS_IRQ_ENABLE: reg_rdata_o <= en_r;
        `EIVM_OFS_IRQ_FLAGS: reg_rdata_o <= flag_r;
        `EIVM_OFS_MASK_A: reg_rdata_o <= mask_a_r;
        `EIVM_OFS_MASK_B: reg_rdata_o <= {5'h00, mask_b_r};
        `EIVM_OFS_MASK_C: reg_rdata_o <= {1'h0, mask_c_r};
        `EIVM_OFS_PIN_LEVEL: reg_rdata_o <= {6'h00, pin_s[19:18]};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_fall_a;
    armed && io_clk_en_i && sense_a == EIVM_SENSE_FALL && pin_prev_r[18] && !pin_s[18];
  endsequence

  // A clear lands one edge after the take, the write or the switch to level mode
  // that causes it, so the second step looks one cycle back for those.
  sequence s_flag_a_up;
    flag_r.ext_a ##1 (flag_r.ext_a || $past(taken[1]) || $past(wr_flags) ||
                      $past(sense_a) == EIVM_SENSE_LOW);
  endsequence

  chk_reset_vector: assert property ($fell(rst_i) |-> vector_o == `EIVM_VEC_RESET && !irq_o)
    else $error("vector not at reset word after reset");
  chk_ext_a_vec: assert property (req[1] |=> irq_o && vector_o == `EIVM_VEC_EXT_A)
    else $error("pin a vector wrong");
  chk_ext_b_vec: assert property (req[2] && !req[1] |=> vector_o == `EIVM_VEC_EXT_B)
    else $error("pin b vector wrong");
  chk_group_vec: assert property (
    req[11] && req[10:0] == '0 |=> vector_o == `EIVM_VEC_GRP_A)
    else $error("group a vector wrong");
  chk_group_c_vec: assert property (req == 21'h100000 |=> vector_o == `EIVM_VEC_GRP_C)
    else $error("group c vector wrong");
  chk_periph_vec: assert property (
    req[3] && req[2:0] == '0 |=> vector_o == `EIVM_VEC_PERIPH_FIRST)
    else $error("first peripheral vector wrong");
  chk_no_fetch: assert property (req == '0 |=> !irq_o && $stable(vector_o))
    else $error("request without enabled source");
  chk_group_a_set: assert property (chg_a |=> flag_r.grp_a)
    else $error("group a change lost");
  chk_group_b_set: assert property (chg_b |=> flag_r.grp_b)
    else $error("group b change lost");
  chk_group_c_set: assert property (chg_c |=> flag_r.grp_c)
    else $error("group c change lost");
  chk_fall_edge: assert property (s_fall_a |=> s_flag_a_up)
    else $error("falling edge did not set flag");
  // The request is registered, so each cycle of low level shows one cycle later.
  chk_level_req: assert property (
    (en_r.gie && en_r.ext_a && lvl_a) [*2] |-> irq_o [*2])
    else $error("low level request dropped");
  chk_edge_halt: assert property (!io_clk_en_i && !flag_r.ext_a |=> !flag_r.ext_a)
    else $error("edge seen with I/O clock halted");
  chk_level_flag: assert property (sense_b == EIVM_SENSE_LOW |=> !flag_r.ext_b)
    else $error("flag set in level mode");
  chk_group_gate: assert property (!en_r.gie || !en_r.grp_b |-> !req[19])
    else $error("group request without enables");

endmodule
`default_nettype wire

// ==== verification/eivm_core_model.sv ====
// Processor core model that takes vectors from the interrupt map.
`timescale 1ns/10ps
`default_nettype none

module eivm_core_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Bench control
  input wire logic ack_en_i,
  input wire logic slow_i,
  // Block side
  input wire logic irq_i,
  input wire logic [15:0] vector_i,
  output logic core_ack_o,
  output logic [15:0] taken_vec_o
);
  logic [2:0] cnt_r;

  // The count restarts after each take, so two takes are never closer than
  // the flag needs to drop the request.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !ack_en_i || !irq_i) begin
      cnt_r <= 3'h0;
      core_ack_o <= 1'b0;
    end else if (cnt_r == (slow_i ? 3'h5 : 3'h2)) begin
      cnt_r <= 3'h0;
      core_ack_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      core_ack_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      taken_vec_o <= 16'h0000;
    end else if (core_ack_o && irq_i) begin
      taken_vec_o <= vector_i;
    end
  end
endmodule

`default_nettype wire

// ==== verification/eivm_top_tb.sv ====
// Self-checking bench for the interrupt and vector map block.
`timescale 1ns/10ps
`default_nettype none

module eivm_top_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic io_clk_en = 1'b1;
  logic pin_a = 1'b1;
  logic pin_b = 1'b1;
  logic [17:0] watch = '0;
  logic [14:0] periph = '0;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic ack_en = 1'b0;
  logic slow = 1'b0;
  logic core_ack;
  logic irq;
  logic [15:0] vector;
  logic [15:0] taken;
  logic [7:0] rdata;
  logic [20:0] ack_taken;
  logic [20:0] seen_oh;
  int miscompares = 0;
  int checked = 0;
  int pc_pin[6] = '{0, 7, 8, 10, 11, 17};
  logic [15:0] pc_vec[6] = '{16'h000B, 16'h000B, 16'h0013, 16'h0013, 16'h0014, 16'h0014};
  logic [7:0] sense[3] = '{8'h02, 8'h03, 8'h01};
  logic lvl[3] = '{1'b0, 1'b1, 1'b0};
  int pr_bit[4] = '{0, 7, 8, 14};
  logic [15:0] pr_vec[4] = '{16'h0003, 16'h000A, 16'h000C, 16'h0012};

  always #50 clk_sys_i = ~clk_sys_i;

  eivm_top DUT (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .io_clk_en_i(io_clk_en),
    .ext_irq_pin_a_i(pin_a),
    .ext_irq_pin_b_i(pin_b),
    .change_watch_pins_i(watch),
    .periph_req_i(periph),
    .core_ack_i(core_ack),
    .irq_o(irq),
    .vector_o(vector),
    .ack_taken_o(ack_taken),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata),
    .reg_we_i(we),
    .reg_re_i(re),
    .reg_rdata_o(rdata)
  );

  eivm_core_model core (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .ack_en_i(ack_en),
    .slow_i(slow),
    .irq_i(irq),
    .vector_i(vector),
    .core_ack_o(core_ack),
    .taken_vec_o(taken)
  );

  // The one-hot take pulse stands only in the cycle of the acknowledge.
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      seen_oh <= '0;
    end else if (core_ack) begin
      seen_oh <= ack_taken;
    end
  end

  // --------------------------------------------------------------------------
  // Access and check tasks
  // --------------------------------------------------------------------------
  task automatic complete_run();
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string n);
    @(posedge clk_sys_i);
    re <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    re <= 1'b0;
    #1;
    chk(n, {8'h00, rdata}, {8'h00, exp});
  endtask

  // The request rises within eight cycles of its cause.
  task automatic hit(input string n, input logic [15:0] v);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 8) begin
      @(posedge clk_sys_i);
      #1;
      i++;
    end
    chk(n, {15'h0, irq}, 16'h0001);
    chk(n, vector, v);
  endtask

  task automatic gone(input string n);
    int i;
    i = 0;
    while (irq !== 1'b0 && i < 16) begin
      @(posedge clk_sys_i);
      #1;
      i++;
    end
    chk(n, {15'h0, irq}, 16'h0000);
  endtask

  task automatic none(input string n);
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk(n, {15'h0, irq}, 16'h0000);
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys_i);
    miscompares++;
    complete_run();
  end

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    chk("reset_vector", vector, 16'h0000);
    rd(4'h6, 8'h03, "pin_level");
    rd(4'hF, 8'h00, "unmapped");
    wr(4'h3, 8'h81);
    wr(4'h4, 8'h05);
    wr(4'h5, 8'h41);
    wr(4'h1, 8'h39);
    rd(4'h4, 8'h05, "mask_b");
    @(posedge clk_sys_i) ack_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_i) slow <= i[0];
      @(posedge clk_sys_i) watch[pc_pin[i]] <= ~watch[pc_pin[i]];
      hit("group_vec", pc_vec[i]);
      gone("group_ack");
      chk("taken_vec", taken, pc_vec[i]);
      chk("taken_onehot", {15'h0000, seen_oh == (21'h000001 << pc_vec[i])}, 16'h0001);
    end
    @(posedge clk_sys_i) watch <= watch ^ 18'h01202;
    none("masked_pins");
    wr(4'h1, 8'h38);
    @(posedge clk_sys_i) watch[0] <= ~watch[0];
    none("no_global");
    wr(4'h1, 8'h01);
    @(posedge clk_sys_i) watch[7] <= ~watch[7];
    none("no_group_en");
    wr(4'h2, 8'hF8);
    // Pin a edges are cleared by software with the core held off.
    @(posedge clk_sys_i) ack_en <= 1'b0;
    wr(4'h1, 8'h41);
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, sense[i]);
      @(posedge clk_sys_i) pin_a <= lvl[i];
      hit("ext_a_vec", 16'h0001);
      rd(4'h2, 8'h40, "ext_a_flag");
      wr(4'h2, 8'h40);
      gone("ext_a_w1c");
    end
    wr(4'h0, 8'h0D);
    wr(4'h1, 8'h81);
    @(posedge clk_sys_i) pin_b <= 1'b0;
    none("ext_b_wrong_edge");
    @(posedge clk_sys_i) ack_en <= 1'b1;
    @(posedge clk_sys_i) pin_b <= 1'b1;
    hit("ext_b_vec", 16'h0002);
    gone("ext_b_ack");
    chk("taken_vec", taken, 16'h0002);
    chk("taken_onehot", {15'h0000, seen_oh == 21'h000004}, 16'h0001);
    @(posedge clk_sys_i) io_clk_en <= 1'b0;
    @(posedge clk_sys_i) pin_b <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    pin_b <= 1'b1;
    none("edge_clock_off");
    @(posedge clk_sys_i) io_clk_en <= 1'b1;
    none("edge_not_kept");
    @(posedge clk_sys_i) ack_en <= 1'b0;
    wr(4'h1, 8'h41);
    wr(4'h0, 8'h0C);
    hit("level_vec", 16'h0001);
    rd(4'h2, 8'h00, "level_flag");
    repeat (20) @(posedge clk_sys_i);
    #1;
    chk("level_held", {15'h0, irq}, 16'h0001);
    @(posedge clk_sys_i) pin_a <= 1'b1;
    gone("level_off");
    wr(4'h1, 8'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i) periph <= 15'h0001 << pr_bit[i];
      hit("periph_vec", pr_vec[i]);
      @(posedge clk_sys_i) periph <= '0;
      gone("periph_off");
    end
    wr(4'h1, 8'h00);
    @(posedge clk_sys_i) periph <= 15'h0001;
    none("periph_no_global");
    @(posedge clk_sys_i) rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    periph <= '0;
    @(posedge clk_sys_i);
    #1;
    chk("reset_again", vector, 16'h0000);
    complete_run();
  end
endmodule

`default_nettype wire
